// ---- shared/gpev_pkg.sv ----
// shared constants and carrier types for the event-debounced general-purpose port
package gpev_pkg;

	// =====================================================================
	// port geometry
	localparam int PINS = 8;
	localparam int BUSES = 2;
	localparam int BUS_LPC = 0;
	localparam int BUS_SERIAL = 1;

	// =====================================================================
	// configuration space indices (pin select plus the selected pin's set)
	localparam logic [7:0] IDX_PIN_SELECT = 8'hf0;
	localparam logic [7:0] IDX_PIN_CONFIG_ONE = 8'hf1;
	localparam logic [7:0] IDX_PIN_EVENT_ROUTING = 8'hf2;
	localparam logic [7:0] IDX_PIN_CONFIG_TWO = 8'hf3;

	// =====================================================================
	// runtime register offsets from the I/O base address
	localparam logic [15:0] OFS_PORT_DATA_OUT = 16'h0000;
	localparam logic [15:0] OFS_PORT_DATA_IN = 16'h0001;
	localparam logic [15:0] OFS_PORT_EVENT_ENABLE = 16'h0002;
	localparam logic [15:0] OFS_PORT_EVENT_STATUS = 16'h0003;
	localparam logic [15:0] RUNTIME_SPAN = 16'h0004;

	// =====================================================================
	// pin_config_one fields
	localparam int C1_OUT_ENABLE = 0;
	localparam int C1_PUSH_PULL = 1;
	localparam int C1_PULL_UP = 2;
	localparam int C1_LOCK = 3;
	localparam int C1_EVENT_LEVEL = 4;
	localparam int C1_EVENT_POLARITY = 5;
	localparam int C1_DEBOUNCE = 6;
	localparam logic [7:0] C1_PROTECTED = 8'h0f;

	// =====================================================================
	// pin_config_two fields (bus control: bit 5 + bus index)
	localparam int C2_LOAD_PROTECT = 4;
	localparam int C2_BUS_BLOCK_BASE = 5;
	localparam logic [7:0] C2_PROTECTED = 8'h70;

	// =====================================================================
	// reset values
	localparam logic [7:0] PIN_SELECT_RESET = 8'h00;
	localparam logic [7:0] PIN_CONFIG_ONE_RESET = 8'h00;
	localparam logic [7:0] PIN_EVENT_ROUTING_RESET = 8'h01;
	localparam logic [7:0] PIN_CONFIG_TWO_RESET = 8'h00;
	localparam logic [7:0] PORT_DATA_OUT_RESET = 8'hff;
	localparam logic [7:0] PORT_EVENT_ENABLE_RESET = 8'h00;
	localparam logic [7:0] PORT_EVENT_STATUS_RESET = 8'h00;
	localparam logic [7:0] OUTPUT_ONLY_MASK = 8'h00;

	// =====================================================================
	// timing
	localparam int CLOCK_HZ = 25_000_000;
	localparam int DEBOUNCE_MS = 15;
	localparam int DEBOUNCE_CYCLES = (CLOCK_HZ / 1000) * DEBOUNCE_MS;

	// =====================================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic write;
		logic cfgSpace;
		logic [15:0] addr;
		logic [7:0] wdata;
	} gpev_req_t;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} gpev_rsp_t;

endpackage : gpev_pkg

// ---- logic/gpev_port.sv ----
// eight-pin general-purpose port with per-pin configuration and debounced events
//
// Operation
// - eight pins; bit n of each runtime register belongs to pin n
// - runtime registers sit in I/O space at the configured base address
// - config one bit 0 enables the pin output driver
// - config one bit 1 selects push-pull or open-drain output
// - config one bit 2 enables static pull-up for any pin type
// - lock bit blocks writes to data-out, config one 0-3, config two 4-6
// - lock clears only on reset or the unlock strobe
// - load protection without main power kills output and pull-up, and input buffer except on OUTPUT_ONLY pins
// - bus control bits block writes from one bus to protected bits
// - blocked bus still reads the actual protected, data-out, data-in values
// - bus control bits reset to zero, both buses allowed
// - an enabled output drives the stored data-out value
// - data-out reads return stored contents regardless of pin
// - data-in is read-only and returns the actual pin level
// - inactive module blocks LPC runtime access, data-out kept
// - debounce passes a level only after 15 ms without transitions
// - every pin is an event source set up by config one
// - config one bit 4 edge or level, bit 5 polarity
// - status set on active event regardless of enable; write 1 clears
// - pending is status and enable; notify while any pin pending
module gpev_port
	import gpev_pkg::*;
#(
	parameter int DEBOUNCE_TICKS = DEBOUNCE_CYCLES, // stable cycles before an event level passes
	parameter logic [7:0] OUTPUT_ONLY = OUTPUT_ONLY_MASK // pins whose input buffer stays enabled under load protection
) (
	input wire logic clock, // 25 MHz standby clock
	input wire logic rstn, // asynchronous reset, active low
	input wire gpev_req_t lpcReq, // access from the LPC host
	output gpev_rsp_t lpcRsp, // answer to the LPC host
	input wire gpev_req_t sbReq, // access from the serial bus
	output gpev_rsp_t sbRsp, // answer to the serial bus
	input wire logic [15:0] baseAddr, // I/O base from device configuration
	input wire logic moduleActive, // activation bit from device configuration
	input wire logic unlockGpio, // gpio_unlock_bit strobe from serial_bus_lock_control
	input wire logic mainPower, // main supply present, asynchronous
	input wire logic [7:0] pinIn, // port_pin_n levels, asynchronous
	output logic [7:0] pinOut, // pin output value
	output logic [7:0] pinOe, // pin output enable, high while driving
	output logic [7:0] pullUpEn, // static pull-up enable
	output logic [7:0] inputBufEn, // input buffer enable
	output logic notify // system notification, any pin pending
);

	localparam int CW = $clog2(DEBOUNCE_TICKS + 1);

	// =====================================================================
	// state
	logic [7:0] pinSync1, pinSync2;
	logic pwrSync1, pwrSync2;
	logic [7:0] pinSelect;
	logic [7:0] cfg1 [PINS];
	logic [7:0] evr [PINS];
	logic [7:0] cfg2 [PINS];
	logic [7:0] dataOut, eventEnable, eventStatus;
	logic [7:0] filt, filtPrev, eventHit, evClear;
	logic [7:0] next_dataOut, next_eventEnable, next_eventStatus;
	logic [7:0] next_cfg1 [PINS];
	logic [7:0] next_evr [PINS];
	logic [7:0] next_cfg2 [PINS];
	logic [7:0] lockVec, protVec, inLive, blkVec [BUSES];
	gpev_req_t req [BUSES];
	logic [7:0] rdata [BUSES];
	logic [BUSES-1:0] rtHit, cfgHit;
	logic [15:0] rtOfs [BUSES];
	logic [2:0] sel;

	assign req[BUS_LPC] = lpcReq;
	assign req[BUS_SERIAL] = sbReq;
	assign sel = pinSelect[2:0];

	// =====================================================================
	// synchronisers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pinSync1 <= 8'h00;
			pinSync2 <= 8'h00;
			pwrSync1 <= 1'b0;
			pwrSync2 <= 1'b0;
		end else begin
			pinSync1 <= pinIn;
			pinSync2 <= pinSync1;
			pwrSync1 <= mainPower;
			pwrSync2 <= pwrSync1;
		end
	end

	// =====================================================================
	// per-pin protection vectors
	always_comb begin
		for (int n = 0; n < PINS; n++) begin
			lockVec[n] = cfg1[n][C1_LOCK];
			protVec[n] = cfg2[n][C2_LOAD_PROTECT] & ~pwrSync2;
			inLive[n] = ~(protVec[n] & ~OUTPUT_ONLY[n]);
			for (int b = 0; b < BUSES; b++) begin
				blkVec[b][n] = cfg2[n][C2_BUS_BLOCK_BASE + b];
			end
		end
	end

	// =====================================================================
	// address decode and read data per bus
	for (genvar b = 0; b < BUSES; b++) begin : g_bus
		logic lpcBlocked;
		assign lpcBlocked = (b == BUS_LPC) && !moduleActive;
		assign rtOfs[b] = req[b].addr - baseAddr;
		assign rtHit[b] = req[b].valid && !req[b].cfgSpace && !lpcBlocked
			&& (rtOfs[b] < RUNTIME_SPAN);
		assign cfgHit[b] = req[b].valid && req[b].cfgSpace && (req[b].addr[15:8] == 8'h00);

		// reads are never blocked by bus control
		always_comb begin
			rdata[b] = 8'h00;
			if (rtHit[b]) begin
				case (rtOfs[b])
					OFS_PORT_DATA_OUT: rdata[b] = dataOut;
					OFS_PORT_DATA_IN: rdata[b] = pinSync2 & inLive;
					OFS_PORT_EVENT_ENABLE: rdata[b] = eventEnable;
					OFS_PORT_EVENT_STATUS: rdata[b] = eventStatus;
					default: rdata[b] = 8'h00;
				endcase
			end else if (cfgHit[b]) begin
				case (req[b].addr[7:0])
					IDX_PIN_SELECT: rdata[b] = pinSelect;
					IDX_PIN_CONFIG_ONE: rdata[b] = cfg1[sel];
					IDX_PIN_EVENT_ROUTING: rdata[b] = evr[sel];
					IDX_PIN_CONFIG_TWO: rdata[b] = cfg2[sel];
					default: rdata[b] = 8'h00;
				endcase
			end
		end
	end

	// =====================================================================
	// answers, one cycle after each request
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lpcRsp <= '0;
			sbRsp <= '0;
		end else begin
			lpcRsp.ack <= lpcReq.valid;
			lpcRsp.rdata <= lpcReq.write ? 8'h00 : rdata[BUS_LPC];
			sbRsp.ack <= sbReq.valid;
			sbRsp.rdata <= sbReq.write ? 8'h00 : rdata[BUS_SERIAL];
		end
	end

	// =====================================================================
	// register writes; serial bus applied after LPC on a same-cycle clash
	always_comb begin
		logic [7:0] m;
		m = 8'h00;
		next_dataOut = dataOut;
		next_eventEnable = eventEnable;
		evClear = 8'h00;
		for (int n = 0; n < PINS; n++) begin
			next_cfg1[n] = cfg1[n];
			next_evr[n] = evr[n];
			next_cfg2[n] = cfg2[n];
		end
		for (int b = 0; b < BUSES; b++) begin
			if (rtHit[b] && req[b].write) begin
				case (rtOfs[b])
					OFS_PORT_DATA_OUT: begin
						m = ~(lockVec | blkVec[b]);
						next_dataOut = (next_dataOut & ~m) | (req[b].wdata & m);
					end
					OFS_PORT_EVENT_ENABLE: next_eventEnable = req[b].wdata;
					OFS_PORT_EVENT_STATUS: evClear = evClear | req[b].wdata;
					default: m = 8'h00; // data-in writes ignored
				endcase
			end
			if (cfgHit[b] && req[b].write) begin
				m = (lockVec[sel] | blkVec[b][sel]) ? 8'h00 : 8'hff;
				case (req[b].addr[7:0])
					IDX_PIN_CONFIG_ONE: begin
						m = m | ~C1_PROTECTED;
						next_cfg1[sel] = (next_cfg1[sel] & ~m) | (req[b].wdata & m);
					end
					IDX_PIN_CONFIG_TWO: begin
						m = m | ~C2_PROTECTED;
						next_cfg2[sel] = (next_cfg2[sel] & ~m) | (req[b].wdata & m);
					end
					IDX_PIN_EVENT_ROUTING: next_evr[sel] = req[b].wdata;
					default: m = 8'h00;
				endcase
			end
		end
		if (unlockGpio) begin
			for (int n = 0; n < PINS; n++) begin
				next_cfg1[n][C1_LOCK] = 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pinSelect <= PIN_SELECT_RESET;
		end else begin
			for (int b = 0; b < BUSES; b++) begin
				if (cfgHit[b] && req[b].write && req[b].addr[7:0] == IDX_PIN_SELECT) begin
					pinSelect <= req[b].wdata;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int n = 0; n < PINS; n++) begin
				cfg1[n] <= PIN_CONFIG_ONE_RESET;
				evr[n] <= PIN_EVENT_ROUTING_RESET;
				cfg2[n] <= PIN_CONFIG_TWO_RESET;
			end
		end else begin
			for (int n = 0; n < PINS; n++) begin
				cfg1[n] <= next_cfg1[n];
				evr[n] <= next_evr[n];
				cfg2[n] <= next_cfg2[n];
			end
		end
	end

	// data-out holds its value whatever the activation state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dataOut <= PORT_DATA_OUT_RESET;
			eventEnable <= PORT_EVENT_ENABLE_RESET;
		end else begin
			dataOut <= next_dataOut;
			eventEnable <= next_eventEnable;
		end
	end

	// =====================================================================
	// pin drive
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pinOut <= 8'h00;
			pinOe <= 8'h00;
			pullUpEn <= 8'h00;
			inputBufEn <= 8'h00;
		end else begin
			for (int n = 0; n < PINS; n++) begin
				pinOut[n] <= dataOut[n];
				// open-drain only drives the low level
				pinOe[n] <= cfg1[n][C1_OUT_ENABLE] & ~protVec[n]
					& (cfg1[n][C1_PUSH_PULL] | ~dataOut[n]);
				pullUpEn[n] <= cfg1[n][C1_PULL_UP] & ~protVec[n];
				inputBufEn[n] <= inLive[n];
			end
		end
	end

	// =====================================================================
	// debounce filter per pin
	for (genvar n = 0; n < PINS; n++) begin : g_deb
		logic [CW-1:0] cnt;
		logic last;
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				cnt <= '0;
				last <= 1'b0;
				filt[n] <= 1'b0;
			end else if (!cfg1[n][C1_DEBOUNCE]) begin
				cnt <= '0;
				last <= pinSync2[n] & inLive[n];
				filt[n] <= pinSync2[n] & inLive[n];
			end else if ((pinSync2[n] & inLive[n]) != last) begin
				cnt <= '0;
				last <= pinSync2[n] & inLive[n];
			end else if (cnt == CW'(DEBOUNCE_TICKS - 1)) begin
				filt[n] <= last;
			end else begin
				cnt <= cnt + CW'(1);
			end
		end
	end

	// =====================================================================
	// event detection, status and notification
	always_comb begin
		for (int n = 0; n < PINS; n++) begin
			eventHit[n] = (filt[n] == cfg1[n][C1_EVENT_POLARITY])
				&& (cfg1[n][C1_EVENT_LEVEL] || filt[n] != filtPrev[n]);
		end
		// set wins over software or power-loss clear
		next_eventStatus = (eventStatus & ~evClear & ~protVec) | eventHit;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			filtPrev <= 8'h00;
			eventStatus <= PORT_EVENT_STATUS_RESET;
			notify <= 1'b0;
		end else begin
			filtPrev <= filt;
			eventStatus <= next_eventStatus;
			notify <= |(eventStatus & eventEnable);
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	property p_lock_hold;
		cfg1[0][C1_LOCK] |=> dataOut[0] == $past(dataOut[0]);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked data-out changed");

	property p_lock_clear;
		$fell(cfg1[0][C1_LOCK]) |-> $past(unlockGpio);
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock cleared without unlock");

	property p_oe_cause;
		pinOe[0] |-> $past(cfg1[0][C1_OUT_ENABLE]) && !$past(protVec[0]);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("output driven while disabled");

	property p_open_drain;
		pinOe[0] && !$past(cfg1[0][C1_PUSH_PULL]) |-> !pinOut[0];
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain drove high");

	property p_load_protect;
		cfg2[0][C2_LOAD_PROTECT] && !pwrSync2 |=> !pinOe[0] && !pullUpEn[0];
	endproperty
	a_load_protect: assert property (p_load_protect) else $error("load protection failed");

	property p_inactive_keep;
		!moduleActive && lpcReq.valid && lpcReq.write && !sbReq.valid |=> $stable(dataOut);
	endproperty
	a_inactive_keep: assert property (p_inactive_keep) else $error("inactive LPC write took");

	property p_debounce;
		$changed(filt[0]) && $past(cfg1[0][C1_DEBOUNCE]) |-> $past(g_deb[0].cnt == CW'(DEBOUNCE_TICKS - 1));
	endproperty
	a_debounce: assert property (p_debounce) else $error("filter passed early");

	property p_status_sticky;
		eventStatus[0] && !evClear[0] && !protVec[0] |=> eventStatus[0];
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status lost");

	property p_notify;
		(eventStatus & eventEnable) != 8'h00 |=> notify ##0 $past(eventEnable) != 8'h00;
	endproperty
	a_notify: assert property (p_notify) else $error("notify missing");

	property p_no_notify;
		(eventStatus & eventEnable) == 8'h00 |=> !notify;
	endproperty
	a_no_notify: assert property (p_no_notify) else $error("spurious notify");

endmodule : gpev_port

// ---- test/gpev_pin_load.sv ----
// pin-side load model that resolves the level on each port pin
module gpev_pin_load (
	input wire logic clock, // bench clock
	input wire logic [7:0] pinOut, // design drive value
	input wire logic [7:0] pinOe, // design drive enable
	input wire logic [7:0] pullUpEn, // design pull-up enable
	input wire logic [7:0] extVal, // external device drive value
	input wire logic [7:0] extEn, // external device drive enable
	output logic [7:0] level // resolved wire level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] held = 8'h00;

	// an undriven pin without pull-up settles opposite to its last driven level
	always @(posedge clock) begin
		for (int n = 0; n < 8; n++) begin
			if (pinOe[n] || extEn[n] || pullUpEn[n])
				held[n] <= level[n];
		end
	end

	always_comb begin
		for (int n = 0; n < 8; n++) begin
			if (pinOe[n])
				level[n] = pinOut[n];
			else if (extEn[n])
				level[n] = extVal[n];
			else if (pullUpEn[n])
				level[n] = 1'b1;
			else
				level[n] = ~held[n];
		end
	end
endmodule : gpev_pin_load

// ---- test/gpev_port_tb.sv ----
// self-checking bench for the event-debounced general-purpose port
module gpev_port_tb import gpev_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] B = 16'h0300;
	localparam logic [15:0] F0 = {8'h00, IDX_PIN_SELECT};
	localparam logic [15:0] F1 = {8'h00, IDX_PIN_CONFIG_ONE};
	localparam logic [15:0] F3 = {8'h00, IDX_PIN_CONFIG_TWO};
	localparam logic [15:0] DO = B + OFS_PORT_DATA_OUT;
	localparam logic [15:0] DI = B + OFS_PORT_DATA_IN;
	localparam logic [15:0] EN = B + OFS_PORT_EVENT_ENABLE;
	localparam logic [15:0] ST = B + OFS_PORT_EVENT_STATUS;
	typedef struct {
		int b;
		logic w;
		logic c;
		logic [15:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} gpev_row_t;
	logic clock, rstn, moduleActive, unlockGpio, mainPower, notify;
	gpev_req_t req [2];
	gpev_rsp_t rsp [2];
	logic [7:0] pinOut, pinOe, pullUpEn, inputBufEn, level, extVal, extEn, r;
	int errors, samples_checked;
	gpev_row_t rows [13] = '{
		'{0, 0, 1, F1, 8'h00, 8'h00}, '{0, 0, 1, {8'h00, IDX_PIN_EVENT_ROUTING}, 8'h00, 8'h01},
		'{1, 0, 1, F3, 8'h00, 8'h00}, '{0, 0, 0, DO, 8'h00, 8'hff},
		'{1, 0, 0, EN, 8'h00, 8'h00}, '{0, 0, 0, ST, 8'h00, 8'h00},
		'{0, 0, 0, B + 16'h0004, 8'h00, 8'h00}, '{0, 1, 1, F1, 8'h07, 8'h00},
		'{0, 0, 1, F1, 8'h00, 8'h07}, '{1, 1, 0, DO, 8'h5a, 8'h00},
		'{0, 0, 0, DO, 8'h00, 8'h5a}, '{0, 1, 0, EN, 8'h01, 8'h00},
		'{1, 0, 0, EN, 8'h00, 8'h01}};

	gpev_port #(.DEBOUNCE_TICKS(8), .OUTPUT_ONLY(8'h00)) DUT (.clock(clock), .rstn(rstn),
		.lpcReq(req[0]), .lpcRsp(rsp[0]), .sbReq(req[1]), .sbRsp(rsp[1]),
		.baseAddr(B), .moduleActive(moduleActive), .unlockGpio(unlockGpio),
		.mainPower(mainPower), .pinIn(level), .pinOut(pinOut), .pinOe(pinOe),
		.pullUpEn(pullUpEn), .inputBufEn(inputBufEn), .notify(notify));
	gpev_pin_load LOAD (.clock(clock), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
		.extVal(extVal), .extEn(extEn), .level(level));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic give_verdict();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkb

	// one-cycle request, answer sampled once the taking edge has landed
	task automatic acc(input int b, input logic w, input logic c, input logic [15:0] a,
		input logic [7:0] d);
		int i;
		@(posedge clock);
		req[b] <= '{1'b1, w, c, a, d};
		@(posedge clock);
		req[b].valid <= 1'b0;
		for (i = 0; i < 4; i++) begin
			#1;
			if (rsp[b].ack === 1'b1)
				break;
			@(posedge clock);
		end
		if (i == 4) begin
			errors++;
			give_verdict();
		end
		r = rsp[b].rdata;
	endtask : acc

	task automatic rd(input int b, input logic c, input logic [15:0] a, input logic [7:0] e);
		acc(b, 1'b0, c, a, 8'h00);
		chk(r, e);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	task automatic setx(input logic [7:0] v);
		@(posedge clock);
		extVal <= v;
	endtask : setx

	initial begin
		rstn = 1'b0;
		moduleActive = 1'b1;
		unlockGpio = 1'b0;
		mainPower = 1'b1;
		extVal = 8'h00;
		extEn = 8'hff;
		req[0] = '0;
		req[1] = '0;
		errors = 0;
		samples_checked = 0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		cyc(2);
		chk(pinOut, PORT_DATA_OUT_RESET);
		chk(pinOe, 8'h00);
		chkb(notify, 1'b0);
		@(posedge clock);
		extEn <= 8'hfe;
		for (int k = 0; k < 13; k++) begin
			if (rows[k].w)
				acc(rows[k].b, 1'b1, rows[k].c, rows[k].a, rows[k].d);
			else
				rd(rows[k].b, rows[k].c, rows[k].a, rows[k].e);
		end
		cyc(2);
		chk(pinOut, 8'h5a);
		chkb(pinOe[0], 1'b1);
		chkb(pullUpEn[0], 1'b1);
		setx(8'ha5);
		acc(0, 1'b1, 1'b0, DI, 8'hff);
		cyc(4);
		rd(0, 1'b0, DI, 8'ha4);
		// =====================================================================
		// lock, unlock and per-bus blocking on pin 0
		acc(0, 1'b1, 1'b1, F1, 8'h0f);
		acc(0, 1'b1, 1'b0, DO, 8'hff);
		rd(1, 1'b0, DO, 8'hfe);
		acc(1, 1'b1, 1'b1, F1, 8'h00);
		rd(0, 1'b1, F1, 8'h0f);
		@(posedge clock);
		unlockGpio <= 1'b1;
		@(posedge clock);
		unlockGpio <= 1'b0;
		rd(0, 1'b1, F1, 8'h07);
		acc(0, 1'b1, 1'b0, DO, 8'hff);
		acc(1, 1'b1, 1'b1, F3, 8'h20);
		acc(0, 1'b1, 1'b0, DO, 8'h00);
		rd(0, 1'b0, DO, 8'h01);
		rd(0, 1'b1, F3, 8'h20);
		acc(1, 1'b1, 1'b0, DO, 8'h00);
		rd(1, 1'b0, DO, 8'h00);
		acc(1, 1'b1, 1'b1, F3, 8'h00);
		// =====================================================================
		// inactive module and load protection
		@(posedge clock);
		moduleActive <= 1'b0;
		acc(0, 1'b1, 1'b0, DO, 8'h33);
		rd(0, 1'b0, DO, 8'h00);
		rd(1, 1'b0, DO, 8'h00);
		chk(pinOut, 8'h00);
		moduleActive <= 1'b1;
		extEn <= 8'hff;
		acc(1, 1'b1, 1'b1, F3, 8'h10);
		mainPower <= 1'b0;
		cyc(5);
		chkb(pinOe[0], 1'b0);
		chkb(pullUpEn[0], 1'b0);
		chkb(inputBufEn[0], 1'b0);
		mainPower <= 1'b1;
		acc(1, 1'b1, 1'b1, F3, 8'h00);
		extEn <= 8'hfe;
		// =====================================================================
		// rising edge event, enable, notify and write-one clear on pin 1
		acc(0, 1'b1, 1'b1, F0, 8'h01);
		acc(0, 1'b1, 1'b1, F1, 8'h20);
		cyc(4);
		acc(0, 1'b1, 1'b0, ST, 8'hff);
		setx(8'ha7);
		cyc(5);
		rd(0, 1'b0, ST, 8'h02);
		acc(0, 1'b1, 1'b0, EN, 8'h02);
		cyc(2);
		chkb(notify, 1'b1);
		acc(1, 1'b1, 1'b0, ST, 8'h00);
		rd(1, 1'b0, ST, 8'h02);
		acc(1, 1'b1, 1'b0, ST, 8'h02);
		cyc(2);
		chkb(notify, 1'b0);
		// =====================================================================
		// debounced rising edge on pin 3: glitch rejected, steady level passes
		acc(0, 1'b1, 1'b1, F0, 8'h03);
		acc(0, 1'b1, 1'b1, F1, 8'h60);
		setx(8'haf);
		cyc(4);
		setx(8'ha7);
		cyc(14);
		rd(0, 1'b0, ST, 8'h00);
		setx(8'haf);
		cyc(6);
		rd(0, 1'b0, ST, 8'h00);
		cyc(12);
		rd(0, 1'b0, ST, 8'h08);
		acc(0, 1'b1, 1'b0, ST, 8'h08);
		// =====================================================================
		// high level event on pin 2 survives a clear while active
		acc(0, 1'b1, 1'b1, F0, 8'h02);
		acc(0, 1'b1, 1'b1, F1, 8'h30);
		cyc(5);
		acc(0, 1'b1, 1'b0, ST, 8'h04);
		cyc(3);
		rd(0, 1'b0, ST, 8'h04);
		// =====================================================================
		// open-drain on pin 0 releases a high level to the pull-up
		acc(0, 1'b1, 1'b1, F0, 8'h00);
		acc(0, 1'b1, 1'b1, F1, 8'h05);
		cyc(2);
		chkb(pinOe[0], 1'b1);
		acc(0, 1'b1, 1'b0, DO, 8'h01);
		cyc(2);
		chkb(pinOe[0], 1'b0);
		chkb(level[0], 1'b1);
		give_verdict();
	end
endmodule : gpev_port_tb
